// ### rtl/scwp_defines.svh
`ifndef SCWP_DEFINES_SVH
`define SCWP_DEFINES_SVH

// instruction codes, shifted in msb first
`define SCWP_OP_WRITE_STATUS  8'h01
`define SCWP_OP_WRITE_DISABLE 8'h04
`define SCWP_OP_WRITE_ENABLE  8'h06

// status register bit positions
`define SCWP_SR_WDIS  7
`define SCWP_SR_QUAD  6
`define SCWP_SR_BP_HI 5
`define SCWP_SR_BP_LO 2
`define SCWP_SR_WEN   1
`define SCWP_SR_BSY   0

// configuration register bit positions
`define SCWP_CF_DSEL 7
`define SCWP_CF_ORIG 3

// reset values of the register fields
`define SCWP_WDIS_RST 1'h0
`define SCWP_QUAD_RST 1'h0
`define SCWP_BP_RST   4'h0
`define SCWP_DSEL_RST 1'h0
`define SCWP_ORIG_RST 1'h0

// dummy clocks of the quad i/o fast read
`define SCWP_DUMMY_SEL1 4'h8
`define SCWP_DUMMY_SEL0 4'h6

// timing
`define SCWP_MCLK_PERIOD_NS    100
`define SCWP_REG_WRITE_TIME_NS 5000000

// frame shape: completed bytes and bit position
`define SCWP_BYTES_NONE   2'h0
`define SCWP_BYTES_OPCODE 2'h1
`define SCWP_BYTES_STATUS 2'h2
`define SCWP_BYTES_CONFIG 2'h3
`define SCWP_BIT_BOUNDARY 3'h0
`define SCWP_BIT_FIRST    3'h1
`define SCWP_BIT_LAST     3'h7

// protected region sizing, in 64 kbyte blocks
`define SCWP_LEVEL_NONE     4'h0
`define SCWP_LEVEL_ALL      4'h8
`define SCWP_BLOCK_SPAN_ONE 8'h01
`define SCWP_BLOCK_SPAN_ALL 8'h80

`endif

// ### rtl/scwp_pkg.sv
`default_nettype none
package scwp_pkg;
    // register write engine states
    typedef enum logic {
        SCWP_IDLE,
        SCWP_BUSY
    } scwp_state_t;
endpackage
`default_nettype wire

// ### rtl/scwp_frame_rx.sv
`include "scwp_defines.svh"
`default_nettype none
// serial clock domain: assembles opcode and data bytes of one frame
module scwp_frame_rx (
    input  wire logic       sclk_i,
    input  wire logic       rstn_i,
    input  wire logic       cs_n_i,
    input  wire logic       si_i,
    output logic            frame_tog_o,
    output logic [7:0]      opcode_o,
    output logic [7:0]      status_data_o,
    output logic [7:0]      config_data_o,
    output logic [1:0]      byte_cnt_o,
    output logic [2:0]      bit_cnt_o
);
    logic       fresh_reg;   // no edge seen yet in this frame
    logic [6:0] shift_reg;   // bits gathered so far
    logic [7:0] byte_now;    // byte completed by the current edge

    assign byte_now = {shift_reg, si_i};

    // raised asynchronously by chip select, since the serial clock stops outside frames
    always_ff @(posedge sclk_i or posedge cs_n_i or negedge rstn_i) begin
        if (!rstn_i) begin
            fresh_reg <= 1'b1;
        end else if (cs_n_i) begin
            fresh_reg <= 1'b1;
        end else begin
            fresh_reg <= 1'b0;
        end
    end

    // frame counters are kept after the frame so the other domain can read them
    always_ff @(posedge sclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            bit_cnt_o  <= `SCWP_BIT_BOUNDARY;
            byte_cnt_o <= `SCWP_BYTES_NONE;
        end else if (fresh_reg) begin
            bit_cnt_o  <= `SCWP_BIT_FIRST;
            byte_cnt_o <= `SCWP_BYTES_NONE;
        end else begin
            bit_cnt_o <= bit_cnt_o + `SCWP_BIT_FIRST;
            // saturate: bytes after the third are not interpreted
            if (bit_cnt_o == `SCWP_BIT_LAST && byte_cnt_o != `SCWP_BYTES_CONFIG) begin
                byte_cnt_o <= byte_cnt_o + `SCWP_BYTES_OPCODE;
            end
        end
    end

    // sample on rising edges, msb first; all eight bits before use
    always_ff @(posedge sclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            shift_reg <= 7'h00;
        end else if (fresh_reg) begin
            shift_reg <= {6'h00, si_i};
        end else begin
            shift_reg <= byte_now[6:0];
        end
    end

    // completed bytes land in their slot by position in the frame
    always_ff @(posedge sclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            opcode_o      <= 8'h00;
            status_data_o <= 8'h00;
            config_data_o <= 8'h00;
        end else if (!fresh_reg && bit_cnt_o == `SCWP_BIT_LAST) begin
            unique case (byte_cnt_o)
                `SCWP_BYTES_NONE:   opcode_o      <= byte_now;
                `SCWP_BYTES_OPCODE: status_data_o <= byte_now;
                `SCWP_BYTES_STATUS: config_data_o <= byte_now;
                `SCWP_BYTES_CONFIG: opcode_o      <= opcode_o;
            endcase
        end
    end

    // one toggle per frame that saw at least one clock
    always_ff @(posedge sclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            frame_tog_o <= 1'b0;
        end else if (fresh_reg) begin
            frame_tog_o <= ~frame_tog_o;
        end
    end
endmodule
`default_nettype wire

// ### rtl/scwp_region_chk.sv
`include "scwp_defines.svh"
`default_nettype none
// decides whether a 64 kbyte block lies in the protected region
module scwp_region_chk (
    input  wire logic [3:0] level_i,
    input  wire logic       origin_i,
    input  wire logic [6:0] block_i,
    output logic            protected_o
);
    logic [2:0] shift_amt;  // level minus one
    logic [7:0] span;       // protected blocks counted from the origin
    logic [7:0] block_ext;  // block index widened for compare

    always_comb begin
        shift_amt = 3'(level_i - `SCWP_BIT_FIRST);
        block_ext = {1'b0, block_i};
        if (level_i == `SCWP_LEVEL_NONE) begin
            span = 8'h00;
        end else if (level_i >= `SCWP_LEVEL_ALL) begin
            span = `SCWP_BLOCK_SPAN_ALL;
        end else begin
            span = 8'(`SCWP_BLOCK_SPAN_ONE << shift_amt);
        end
        // origin 0 counts from the top of the array, 1 from the bottom
        if (origin_i) begin
            protected_o = block_ext < span;
        end else begin
            protected_o = block_ext >= 8'(`SCWP_BLOCK_SPAN_ALL - span);
        end
    end
endmodule
`default_nettype wire

// ### rtl/scwp_top.sv
// Notes on behaviour
// - origin select otp, 0 top, 1 bottom
// - origin select changes only via completed status write
// - config bit7 dummy select, bit3 origin, rest ignored
// - dummy select 1 gives 8 clocks, else 6
// - status write runs only with write enable latch
// - status write data does not load latch and busy bits
// - hardware protect refuses every status write
// - deselect off byte boundary rejects status write
// - busy during timed write, then latch clears
// - hardware protect: disable bit set, pin low
// - software protect otherwise; protect bits writable
// - protected region refuses program and erase
// - hardware protect left by pin high, or by quad set when a cycle already running completes
// - four line mode disables hardware protect
// - status layout: disable, quad, level, latch, busy
// - opcode 06 alone in frame sets latch, only while no write cycle is running
`include "scwp_defines.svh"
`default_nettype none
module scwp_top #(
    parameter int REG_WRITE_TIME_NS = `SCWP_REG_WRITE_TIME_NS  // register_write_time in ns
) (
    input  wire logic       mclk_i,
    input  wire logic       rstn_i,
    input  wire logic       sclk_i,
    input  wire logic       cs_n_i,
    input  wire logic       si_i,
    input  wire logic       write_protect_n_pin_i,
    input  wire logic       pe_req_i,
    input  wire logic [6:0] pe_block_i,
    output logic [7:0]      status_reg_o,
    output logic [7:0]      config_reg_o,
    output logic [3:0]      dummy_clocks_o,
    output logic            hardware_protect_mode_o,
    output logic            software_protect_mode_o,
    output logic            write_rejected_o,
    output logic            pe_accept_o,
    output logic            pe_refuse_o
);
    // least time rounds up to whole cycles, never under one
    localparam int WRITE_CYCLES_RAW = (REG_WRITE_TIME_NS + `SCWP_MCLK_PERIOD_NS - 1) / `SCWP_MCLK_PERIOD_NS;
    localparam int WRITE_CYCLES     = (WRITE_CYCLES_RAW < 1) ? 1 : WRITE_CYCLES_RAW;
    localparam int CNT_W            = $clog2(WRITE_CYCLES + 1);
    localparam logic [CNT_W-1:0] WRITE_LOAD = CNT_W'(WRITE_CYCLES);
    localparam logic [CNT_W-1:0] CNT_ONE    = CNT_W'(1);

    // serial domain words, static once the frame has ended
    logic       rx_tog;       // toggles once per clocked frame
    logic [7:0] rx_opcode;    // first byte
    logic [7:0] rx_status;    // second byte
    logic [7:0] rx_config;    // third byte
    logic [1:0] rx_bytes;     // completed bytes
    logic [2:0] rx_bits;      // bits past the last boundary

    // synchronisers into the register clock
    logic       cs_meta_reg;
    logic       cs_sync_reg;
    logic       cs_prev_reg;
    logic       wp_meta_reg;
    logic       wp_sync_reg;
    logic       tog_meta_reg;
    logic       tog_sync_reg;
    logic       tog_seen_reg; // toggle value of the last decided frame
    logic [1:0] rise_dly_reg; // lets the toggle catch up with the deselect

    // register write engine
    scwp_pkg::scwp_state_t state_reg;
    logic [CNT_W-1:0]      busy_cnt_reg;
    logic [7:0]            pend_sr_reg;  // status byte awaiting completion
    logic [7:0]            pend_cf_reg;  // config byte awaiting completion
    logic                  pend_cfg_reg; // frame carried a config byte

    // register fields
    logic       wdis_reg;     // status_write_disable
    logic       quad_reg;     // quad_lines_enable
    logic [3:0] bp_reg;       // block_protect_level
    logic       wen_reg;      // write_enable_latch
    logic       wbsy_reg;     // write_in_progress
    logic       dsel_reg;     // dummy_cycle_select
    logic       orig_reg;     // protect_origin_select

    // decode results
    logic       cs_rise;
    logic       decide;
    logic       frame_ok;
    logic       aligned;
    logic       idle;
    logic       do_wen;
    logic       do_wrdi;
    logic       is_wsta;
    logic       wsta_go;
    logic       wsta_rej;
    logic       done;
    logic       hwp;
    logic       pe_prot;
    logic [7:0] sr_view;
    logic [7:0] cf_view;

    scwp_frame_rx u_rx (
        .sclk_i        (sclk_i),
        .rstn_i        (rstn_i),
        .cs_n_i        (cs_n_i),
        .si_i          (si_i),
        .frame_tog_o   (rx_tog),
        .opcode_o      (rx_opcode),
        .status_data_o (rx_status),
        .config_data_o (rx_config),
        .byte_cnt_o    (rx_bytes),
        .bit_cnt_o     (rx_bits)
    );

    scwp_region_chk u_region (
        .level_i     (bp_reg),
        .origin_i    (orig_reg),
        .block_i     (pe_block_i),
        .protected_o (pe_prot)
    );

    // two flops on chip select, the protect pin and the frame toggle
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cs_meta_reg  <= 1'b1;
            cs_sync_reg  <= 1'b1;
            cs_prev_reg  <= 1'b1;
            wp_meta_reg  <= 1'b1;
            wp_sync_reg  <= 1'b1;
            tog_meta_reg <= 1'b0;
            tog_sync_reg <= 1'b0;
        end else begin
            cs_meta_reg  <= cs_n_i;
            cs_sync_reg  <= cs_meta_reg;
            cs_prev_reg  <= cs_sync_reg;
            wp_meta_reg  <= write_protect_n_pin_i;
            wp_sync_reg  <= wp_meta_reg;
            tog_meta_reg <= rx_tog;
            tog_sync_reg <= tog_meta_reg;
        end
    end

    // delay the deselect so a toggle racing it is already synchronised
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rise_dly_reg <= 2'h0;
            tog_seen_reg <= 1'b0;
        end else begin
            rise_dly_reg <= {rise_dly_reg[0], cs_rise};
            if (decide) begin
                tog_seen_reg <= tog_sync_reg;
            end
        end
    end

    // instruction decode, once per frame after deselect
    always_comb begin
        cs_rise  = cs_sync_reg & ~cs_prev_reg;
        decide   = rise_dly_reg[1];
        idle     = (state_reg == scwp_pkg::SCWP_IDLE);
        // four line mode turns the pin into data, so it no longer guards writes
        hwp      = wdis_reg & ~wp_sync_reg & ~quad_reg;
        // a frame with no clocks, or one already reselected, is dropped
        frame_ok = decide & cs_sync_reg & (tog_sync_reg != tog_seen_reg) & (rx_bytes != `SCWP_BYTES_NONE);
        aligned  = (rx_bits == `SCWP_BIT_BOUNDARY);
        do_wen   = frame_ok & idle & aligned & (rx_bytes == `SCWP_BYTES_OPCODE)
                   & (rx_opcode == `SCWP_OP_WRITE_ENABLE);
        do_wrdi  = frame_ok & idle & aligned & (rx_bytes == `SCWP_BYTES_OPCODE)
                   & (rx_opcode == `SCWP_OP_WRITE_DISABLE);
        is_wsta  = frame_ok & (rx_opcode == `SCWP_OP_WRITE_STATUS);
        // needs a whole data byte, the latch, no hardware protect and no cycle running
        wsta_go  = is_wsta & aligned & (rx_bytes >= `SCWP_BYTES_STATUS)
                   & wen_reg & ~hwp & idle;
        wsta_rej = is_wsta & ~wsta_go;
        done     = ~idle & (busy_cnt_reg == CNT_ONE);
    end

    // engine state: idle until an accepted status write, busy for the write time
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_reg <= scwp_pkg::SCWP_IDLE;
        end else begin
            unique case (state_reg)
                scwp_pkg::SCWP_IDLE: begin
                    if (wsta_go) begin
                        state_reg <= scwp_pkg::SCWP_BUSY;
                    end
                end
                scwp_pkg::SCWP_BUSY: begin
                    if (done) begin
                        state_reg <= scwp_pkg::SCWP_IDLE;
                    end
                end
            endcase
        end
    end

    // self-timed cycle counter
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            busy_cnt_reg <= '0;
        end else if (wsta_go) begin
            busy_cnt_reg <= WRITE_LOAD;
        end else if (!idle) begin
            busy_cnt_reg <= busy_cnt_reg - CNT_ONE;
        end
    end

    // written bytes wait here; fields change only at completion
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pend_sr_reg  <= 8'h00;
            pend_cf_reg  <= 8'h00;
            pend_cfg_reg <= 1'b0;
        end else if (wsta_go) begin
            pend_sr_reg  <= rx_status;
            pend_cf_reg  <= rx_config;
            pend_cfg_reg <= (rx_bytes == `SCWP_BYTES_CONFIG);
        end
    end

    // write enable latch: clears on completion or write disable
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wen_reg <= 1'b0;
        end else if (done || do_wrdi) begin
            wen_reg <= 1'b0;
        end else if (do_wen) begin
            wen_reg <= 1'b1;
        end
    end

    // busy flag readable throughout the cycle, set only by hardware
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wbsy_reg <= 1'b0;
        end else if (wsta_go) begin
            wbsy_reg <= 1'b1;
        end else if (done) begin
            wbsy_reg <= 1'b0;
        end
    end

    // status fields; latch and busy positions of the data byte are ignored
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wdis_reg <= `SCWP_WDIS_RST;
            quad_reg <= `SCWP_QUAD_RST;
            bp_reg   <= `SCWP_BP_RST;
        end else if (done) begin
            quad_reg <= pend_sr_reg[`SCWP_SR_QUAD];
            // protect bits frozen if hardware protect arrived mid-cycle
            if (!hwp) begin
                wdis_reg <= pend_sr_reg[`SCWP_SR_WDIS];
                bp_reg   <= pend_sr_reg[`SCWP_SR_BP_HI:`SCWP_SR_BP_LO];
            end
        end
    end

    // config fields: only bit7 and bit3 are kept, the rest is dropped
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            dsel_reg <= `SCWP_DSEL_RST;
            orig_reg <= `SCWP_ORIG_RST;
        end else if (done && pend_cfg_reg) begin
            dsel_reg <= pend_cf_reg[`SCWP_CF_DSEL];
            // one-time bit: a write can set it but never clear it
            orig_reg <= orig_reg | pend_cf_reg[`SCWP_CF_ORIG];
        end
    end

    // register views with reserved positions at zero
    always_comb begin
        sr_view = 8'h00;
        sr_view[`SCWP_SR_WDIS] = wdis_reg;
        sr_view[`SCWP_SR_QUAD] = quad_reg;
        sr_view[`SCWP_SR_BP_HI:`SCWP_SR_BP_LO] = bp_reg;
        sr_view[`SCWP_SR_WEN]  = wen_reg;
        sr_view[`SCWP_SR_BSY]  = wbsy_reg;
        cf_view = 8'h00;
        cf_view[`SCWP_CF_DSEL] = dsel_reg;
        cf_view[`SCWP_CF_ORIG] = orig_reg;
    end

    // all outputs registered; views lag their fields by one cycle
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            status_reg_o            <= 8'h00;
            config_reg_o            <= 8'h00;
            dummy_clocks_o          <= `SCWP_DUMMY_SEL0;
            hardware_protect_mode_o <= 1'b0;
            software_protect_mode_o <= 1'b1;
            write_rejected_o        <= 1'b0;
        end else begin
            status_reg_o            <= sr_view;
            config_reg_o            <= cf_view;
            dummy_clocks_o          <= dsel_reg ? `SCWP_DUMMY_SEL1 : `SCWP_DUMMY_SEL0;
            hardware_protect_mode_o <= hwp;
            software_protect_mode_o <= ~hwp;
            write_rejected_o        <= wsta_rej;
        end
    end

    // program and erase gate: refuse any block inside the protected region
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pe_accept_o <= 1'b0;
            pe_refuse_o <= 1'b0;
        end else begin
            pe_accept_o <= pe_req_i & ~pe_prot;
            pe_refuse_o <= pe_req_i & pe_prot;
        end
    end
endmodule
`default_nettype wire

// ### sim/scwp_host_model.sv
`default_nettype none
// host end of the serial link: the link clock runs only inside frames
module scwp_host_model (
    output logic sclk_o,
    output logic cs_n_o,
    output logic si_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle link: deselected, clock parked low
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        si_o   = 1'b0;
    end

    // one frame of nbits, msb first; bits change while the clock is low
    task automatic xfer(input logic [23:0] data, input int nbits);
        #700; // deselect gap, longer than six register clocks
        cs_n_o = 1'b0;
        #20;
        for (int i = 0; i < nbits; i++) begin
            si_o = data[23-i];
            #32 sclk_o = 1'b1;
            #32 sclk_o = 1'b0;
        end
        #20 cs_n_o = 1'b1;
        si_o = ~si_o; // a released line must not keep its last bit
    endtask
endmodule
`default_nettype wire

// ### sim/scwp_top_chk.sv
`default_nettype none
// watches the register block ports on the register clock
module scwp_top_chk #(
    parameter int REG_WRITE_TIME_NS = 5000000
) (
    input wire logic       mclk_i,
    input wire logic       rstn_i,
    input wire logic       pe_req_i,
    input wire logic [7:0] status_reg_o,
    input wire logic [7:0] config_reg_o,
    input wire logic [3:0] dummy_clocks_o,
    input wire logic       hardware_protect_mode_o,
    input wire logic       software_protect_mode_o,
    input wire logic       write_rejected_o,
    input wire logic       pe_accept_o,
    input wire logic       pe_refuse_o
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int WRITE_CYCLES = (REG_WRITE_TIME_NS + 99) / 100;
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rstn_i);

    logic [31:0] busy_cnt; // length of the current busy run

    // busy run length; too long for a repetition, so it is counted
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            busy_cnt <= '0;
        end else if (status_reg_o[0]) begin
            busy_cnt <= busy_cnt + 32'h1;
        end else begin
            busy_cnt <= '0;
        end
    end

    sequence pe_ask_s;
        pe_req_i;
    endsequence
    sequence pe_one_s;
        pe_accept_o ^ pe_refuse_o;
    endsequence
    sequence busy_done_s;
        !status_reg_o[0] && !status_reg_o[1];
    endsequence

    dummy_map_a: assert property (dummy_clocks_o == (config_reg_o[7] ? 4'h8 : 4'h6))
        else $error("dummy clock count does not follow dummy select");
    reserved_zero_a: assert property ((config_reg_o & 8'h77) == 8'h00)
        else $error("reserved config bit set");
    mode_split_a: assert property (hardware_protect_mode_o != software_protect_mode_o)
        else $error("protect modes not exclusive");
    hw_cause_a: assert property (hardware_protect_mode_o |-> status_reg_o[7] && !status_reg_o[6])
        else $error("hardware protect without disable bit or with quad lines");
    origin_otp_a: assert property (!$fell(config_reg_o[3]))
        else $error("origin select cleared");
    origin_write_a: assert property ($rose(config_reg_o[3]) |-> $past(status_reg_o[0]))
        else $error("origin select changed outside a status write");
    hw_frozen_a: assert property (hardware_protect_mode_o && $past(hardware_protect_mode_o)
        |-> $stable(status_reg_o[7]) && $stable(status_reg_o[5:2]))
        else $error("protected bits changed in hardware protect");
    pe_answer_a: assert property (pe_ask_s |=> pe_one_s)
        else $error("program request without single answer");
    pe_quiet_a: assert property (!pe_req_i |=> !pe_accept_o && !pe_refuse_o)
        else $error("program answer without request");
    busy_end_a: assert property ($fell(status_reg_o[0]) |-> busy_done_s
        ##0 (busy_cnt inside {[WRITE_CYCLES-1 : WRITE_CYCLES+1]}))
        else $error("write cycle length or latch release wrong");
    busy_needs_wel_a: assert property ($rose(status_reg_o[0]) |-> status_reg_o[1])
        else $error("write started without enable latch");
    reject_quiet_a: assert property (write_rejected_o |=> !write_rejected_o
        && $stable(status_reg_o[7:2]) && $stable(config_reg_o))
        else $error("refused write changed state");
endmodule
`default_nettype wire

// ### sim/scwp_top_tb.sv
`default_nettype none
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin miscompares++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp); end end
module scwp_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int REG_WRITE_TIME_NS = 1000; // ten register clocks of busy
    logic       mclk_i, rstn_i, sclk_i, cs_n_i, si_i, write_protect_n_pin_i, pe_req_i;
    logic [6:0] pe_block_i;
    logic [7:0] status_reg_o, config_reg_o, r, c;
    logic [3:0] dummy_clocks_o;
    logic       hardware_protect_mode_o, software_protect_mode_o, write_rejected_o;
    logic       pe_accept_o, pe_refuse_o;
    int         miscompares = 0;
    int         cmp_count = 0;
    int         seed = 32'hd1de;
    logic [5:0] e_sr; // expected disable, quad, level fields
    logic       e_ds, e_or; // expected dummy and origin select

    // 10 MHz register clock
    initial begin
        mclk_i = 1'b0;
        forever #50 mclk_i = ~mclk_i;
    end

    scwp_host_model u_scwp_host_model (.sclk_o(sclk_i), .cs_n_o(cs_n_i), .si_o(si_i));
    scwp_top #(.REG_WRITE_TIME_NS(REG_WRITE_TIME_NS)) u_scwp_top (.mclk_i, .rstn_i, .sclk_i, .cs_n_i,
        .si_i, .write_protect_n_pin_i, .pe_req_i, .pe_block_i, .status_reg_o, .config_reg_o,
        .dummy_clocks_o, .hardware_protect_mode_o, .software_protect_mode_o, .write_rejected_o,
        .pe_accept_o, .pe_refuse_o);

    // verdict and end of run
    task automatic complete_run();
        $display("miscompares=%0d cmp_count=%0d", miscompares, cmp_count);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // 0 latch set, 1 busy, 2 idle, 3 refusal pulse
    function automatic logic probe(input int sel);
        case (sel)
            0: return status_reg_o[1];
            1: return status_reg_o[0];
            2: return !status_reg_o[0];
            default: return write_rejected_o;
        endcase
    endfunction

    // bounded wait; a pulse is seen since every cycle is polled
    task automatic wait_for(input int sel, input int limit);
        int n;
        n = 0;
        while (probe(sel) !== 1'b1) begin
            @(posedge mclk_i);
            #2;
            n++;
            if (n > limit) begin
                miscompares++;
                $display("[ERR] t=%0t got=%h exp=%h", $time, sel, 1);
                complete_run();
            end
        end
    endtask

    // region size doubles per level, from the top or the bottom
    function automatic logic prot(input logic [3:0] lv, input logic org, input logic [6:0] b);
        int n;
        n = (lv == 4'h0) ? 0 : (lv >= 4'h8) ? 128 : (1 << (lv - 4'h1));
        return org ? (int'(b) < n) : (int'(b) >= 128 - n);
    endfunction

    task automatic check_regs(input logic write_enable_latch);
        `CHK(status_reg_o, {e_sr, write_enable_latch, 1'b0})
        `CHK(config_reg_o, {e_ds, 3'h0, e_or, 3'h0})
        `CHK(dummy_clocks_o, e_ds ? 4'h8 : 4'h6)
    endtask

    task automatic pe_check(input logic [6:0] b);
        logic p;
        p = prot(e_sr[3:0], e_or, b);
        @(posedge mclk_i);
        #2;
        pe_req_i = 1'b1;
        pe_block_i = b;
        @(posedge mclk_i);
        #2;
        pe_req_i = 1'b0;
        `CHK({pe_accept_o, pe_refuse_o}, {~p, p})
    endtask

    // enable, then status write of nb bits; ok says whether it may run
    task automatic wr_status(input logic [7:0] s, input logic [7:0] cf, input int nb, input logic ok);
        u_scwp_host_model.xfer(24'h060000, 8);
        wait_for(0, 20);
        u_scwp_host_model.xfer({8'h01, s, cf}, nb);
        if (ok) begin
            wait_for(1, 20);
            `CHK(status_reg_o[1:0], 2'h3)
            wait_for(2, 40);
            e_sr = s[7:2];
            if (nb > 16) begin
                e_ds = cf[7];
                e_or = e_or | cf[3];
            end
            check_regs(1'b0);
            pe_check(7'h00);
            pe_check(7'h7f);
            pe_check(7'($random(seed)));
        end else begin
            wait_for(3, 15);
            @(posedge mclk_i);
            #2;
            check_regs(1'b1);
        end
    endtask

    initial begin
        {rstn_i, pe_req_i, pe_block_i, e_sr, e_ds, e_or} = '0;
        write_protect_n_pin_i = 1'b1;
        repeat (16) @(posedge mclk_i);
        #2 rstn_i = 1'b1;
        repeat (3) @(posedge mclk_i);
        #2;
        check_regs(1'b0);
        `CHK({hardware_protect_mode_o, software_protect_mode_o}, 2'h1)
        // write without the latch, then a clipped enable frame
        u_scwp_host_model.xfer(24'h01ff00, 16);
        wait_for(3, 15);
        u_scwp_host_model.xfer(24'h0c0000, 7);
        repeat (12) @(posedge mclk_i);
        #2;
        `CHK(status_reg_o[1], 1'b0)
        // enable, then write disable: the latch drops and a status write is refused
        u_scwp_host_model.xfer(24'h060000, 8);
        wait_for(0, 20);
        u_scwp_host_model.xfer(24'h040000, 8);
        u_scwp_host_model.xfer(24'h01ff00, 16);
        wait_for(3, 15);
        `CHK(status_reg_o[1], 1'b0)
        // random writes; origin held clear at first, then set
        for (int i = 0; i < 6; i++) begin
            r = 8'($random(seed));
            c = 8'($random(seed));
            c = (i < 3) ? (c & 8'hf7) : (c | 8'h08);
            wr_status(r, c, (i == 2) ? 16 : 24, 1'b1);
        end
        wr_status(8'h3c, 8'h80, 13, 1'b0);
        // hardware protect entered by the pin, left by the pin
        wr_status(8'h88, 8'h00, 24, 1'b1);
        write_protect_n_pin_i = 1'b0;
        repeat (6) @(posedge mclk_i);
        #2;
        `CHK({hardware_protect_mode_o, software_protect_mode_o}, 2'h2)
        wr_status(8'h00, 8'h80, 24, 1'b0);
        write_protect_n_pin_i = 1'b1;
        repeat (6) @(posedge mclk_i);
        #2;
        `CHK({hardware_protect_mode_o, software_protect_mode_o}, 2'h1)
        // quad lines on: the pin no longer gates writes; sweep levels 0 to 8
        wr_status(8'hc0, 8'h00, 24, 1'b1);
        write_protect_n_pin_i = 1'b0;
        repeat (6) @(posedge mclk_i);
        #2;
        `CHK({hardware_protect_mode_o, software_protect_mode_o}, 2'h1)
        for (int l = 0; l < 9; l++) begin
            wr_status({2'h3, 4'(l), 2'h0}, 8'h00, 16, 1'b1);
        end
        complete_run();
    end
endmodule

bind scwp_top scwp_top_chk #(.REG_WRITE_TIME_NS(REG_WRITE_TIME_NS)) u_scwp_top_chk (.mclk_i, .rstn_i,
    .pe_req_i, .status_reg_o, .config_reg_o, .dummy_clocks_o, .hardware_protect_mode_o,
    .software_protect_mode_o, .write_rejected_o, .pe_accept_o, .pe_refuse_o);
`default_nettype wire
